//--- tb/cpu_bus_model.sv
// Purpose: Core side of the register port, with interrupt service.
// Assumes: Slave never stalls; read data stand one cycle after rd.
// Notes:   Idle write data show the inverse so stale values never pass.
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
    input  wire logic       clock,
    input  wire logic [7:0] rdata,
    output logic      [2:0] addr,
    output logic      [7:0] wdata,
    output logic            wr,
    output logic            rd,
    output logic            irq_ack
);
    initial begin
        addr = 3'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        irq_ack = 1'b0;
    end
    task automatic write_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        wdata <= ~d;
    endtask
    task automatic read_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        @(negedge clock);
        d = rdata;
        @(posedge clock);
    endtask
    // Extra edge lets the cleared level settle before anyone looks
    task automatic service();
        @(posedge clock);
        irq_ack <= 1'b1;
        @(posedge clock);
        irq_ack <= 1'b0;
        @(posedge clock);
    endtask
endmodule
`default_nettype wire

//--- tb/timer8_compare_waveform_tb.sv
// Purpose: Self-checking bench for the eight-bit timer.
// Assumes: Prescale select 1 ticks every clock; crystal is 16 clocks.
// Notes:   Counts are judged by differences, so start latency is free.
`timescale 1ns/1ps
`default_nettype none
module timer8_compare_waveform_tb;
    import timer8_pkg::*;
    logic       clock = 1'b0;
    logic       arst_n = 1'b0;
    logic       crystal_pin_in = 1'b0;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, rv, r0;
    logic       wr, rd, irq_ack, crystal_pin_out, compare_irq, overflow_irq;
    logic       compare_output, compare_output_oe;
    int         fails = 0;
    int         cmp_count = 0;
    int         seed = 32'h8ecd;
    int         per[$];
    int         i;
    always #25 clock = ~clock;
    initial begin
        #7;
        forever #400 crystal_pin_in = ~crystal_pin_in;
    end
    cpu_bus_model cpu (.clock(clock), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .irq_ack(irq_ack));
    timer8_compare_waveform DUT (.clock(clock), .arst_n(arst_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .crystal_pin_in(crystal_pin_in),
        .crystal_pin_out(crystal_pin_out), .irq_ack(irq_ack), .compare_irq(compare_irq),
        .overflow_irq(overflow_irq), .compare_output(compare_output),
        .compare_output_oe(compare_output_oe));
    function automatic logic [7:0] ctl(input logic [2:0] cs, input logic [1:0] wm,
                                       input logic [1:0] com, input logic f);
        ctl = {f, wm[0], com, wm[1], cs};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Spaces two reads so their strobes sit n cycles apart
    task automatic gap(input int n);
        repeat (n - 3) @(posedge clock);
    endtask
    task automatic print_verdict();
        if (fails == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clock);
        fails++;
        print_verdict();
    end
    initial begin
        repeat (6) @(posedge clock);
        arst_n <= 1'b1;
        for (i = 0; i < 8; i++) begin
            cpu.read_reg(i[2:0], rv);
            chk(rv, 8'h00);
        end
        for (i = 0; i < 4; i++) begin
            r0 = 8'($random(seed));
            cpu.write_reg(ADDR_COUNT, r0);
            cpu.read_reg(ADDR_COUNT, rv);
            chk(rv, r0);
        end
        // Sequence length per mode: normal, phase correct, clear-on-match, fast
        per = {256, 510, 10, 256};
        cpu.write_reg(ADDR_COMPARE, 8'h09);
        for (i = 0; i < 4; i++) begin
            cpu.write_reg(ADDR_CONTROL, ctl(3'h1, i[1:0], 2'b00, 1'b0));
            cpu.write_reg(ADDR_COUNT, 8'h00);
            cpu.read_reg(ADDR_COUNT, r0);
            gap(per[i]);
            cpu.read_reg(ADDR_COUNT, rv);
            chk(rv, r0);
            if (i == 2) chk({7'h0, rv > 8'h09}, 8'h00);
        end
        cpu.write_reg(ADDR_CONTROL, 8'h00);
        cpu.write_reg(ADDR_FLAGS, 8'h03);
        cpu.write_reg(ADDR_IRQ_EN, 8'h03);
        cpu.write_reg(ADDR_COMPARE, 8'h02);
        cpu.write_reg(ADDR_COUNT, 8'hFC);
        cpu.write_reg(ADDR_CONTROL, ctl(3'h1, 2'b00, 2'b00, 1'b0));
        cpu.read_reg(ADDR_COUNT, r0);
        gap(7);
        cpu.read_reg(ADDR_COUNT, rv);
        chk(rv, r0 + 8'h07);
        cpu.write_reg(ADDR_CONTROL, 8'h00);
        chk({6'h0, compare_irq, overflow_irq}, 8'h03);
        cpu.write_reg(ADDR_IRQ_EN, 8'h00);
        @(negedge clock);
        chk({6'h0, compare_irq, overflow_irq}, 8'h00);
        cpu.write_reg(ADDR_IRQ_EN, 8'h03);
        cpu.service();
        chk({6'h0, compare_irq, overflow_irq}, 8'h01);
        cpu.service();
        cpu.read_reg(ADDR_FLAGS, rv);
        chk(rv, 8'h00);
        // Count write equal to compare must not raise a match
        cpu.write_reg(ADDR_COMPARE, 8'h40);
        cpu.write_reg(ADDR_COUNT, 8'h40);
        cpu.write_reg(ADDR_CONTROL, ctl(3'h1, 2'b00, 2'b00, 1'b0));
        gap(12);
        cpu.write_reg(ADDR_CONTROL, 8'h00);
        cpu.read_reg(ADDR_FLAGS, rv);
        chk(rv, 8'h00);
        cpu.write_reg(ADDR_PORT, 8'h03);
        cpu.write_reg(ADDR_CONTROL, ctl(3'h0, 2'b00, 2'b11, 1'b1));
        @(negedge clock);
        chk({6'h0, compare_output_oe, compare_output}, 8'h03);
        cpu.read_reg(ADDR_FLAGS, rv);
        chk(rv, 8'h00);
        cpu.write_reg(ADDR_CONTROL, ctl(3'h0, 2'b11, 2'b11, 1'b0));
        @(negedge clock);
        chk({7'h0, compare_output}, 8'h01);
        cpu.write_reg(ADDR_CONTROL, ctl(3'h0, 2'b00, 2'b10, 1'b1));
        cpu.write_reg(ADDR_CONTROL, ctl(3'h0, 2'b11, 2'b01, 1'b1));
        @(negedge clock);
        chk({7'h0, compare_output}, 8'h00);
        cpu.write_reg(ADDR_CONTROL, 8'h00);
        @(negedge clock);
        chk({7'h0, compare_output}, 8'h01);
        cpu.write_reg(ADDR_ASYNC, 8'h08);
        cpu.write_reg(ADDR_CONTROL, ctl(3'h1, 2'b00, 2'b00, 1'b0));
        cpu.read_reg(ADDR_COUNT, r0);
        gap(80);
        cpu.read_reg(ADDR_COUNT, rv);
        chk(rv, r0 + 8'h05);
        print_verdict();
    end
endmodule
`default_nettype wire

//--- tb/timer8_props.sv
// Purpose: Port-level checks for the eight-bit timer.
// Assumes: Only the top module's ports are visible.
// Notes:   Clock select and output mode are shadowed from bus writes.
`timescale 1ns/1ps
`default_nettype none
module timer8_props
    import timer8_pkg::*;
(
    input wire logic       clock,
    input wire logic       arst_n,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       crystal_pin_in,
    input wire logic       crystal_pin_out,
    input wire logic       irq_ack,
    input wire logic       compare_irq,
    input wire logic       overflow_irq,
    input wire logic       compare_output,
    input wire logic       compare_output_oe
);
    logic [2:0] cs_sh;
    logic [1:0] com_sh;
    wire        wr_ctl = wr && addr == ADDR_CONTROL;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cs_sh  <= 3'h0;
            com_sh <= 2'h0;
        end else if (wr_ctl) begin
            cs_sh  <= wdata[2:0];
            com_sh <= wdata[5:4];
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    sequence count_wr_stopped;
        wr && addr == ADDR_COUNT && cs_sh == 3'h0;
    endsequence
    sequence count_rd;
        rd && addr == ADDR_COUNT;
    endsequence
    // Stopped counter must hand back exactly what was written
    a_count_hold: assert property (count_wr_stopped ##1 !wr ##1 count_rd |=>
        rdata == $past(wdata, 3)) else $error("count changed while stopped");
    a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
        else $error("read data outside read answer");
    a_mask_cmp: assert property (wr && addr == ADDR_IRQ_EN && !wdata[FLG_MATCH]
        |=> !compare_irq) else $error("masked compare request seen");
    a_mask_ovf: assert property (wr && addr == ADDR_IRQ_EN && !wdata[FLG_OVF]
        |=> !overflow_irq) else $error("masked overflow request seen");
    a_w1c_match: assert property (wr && addr == ADDR_FLAGS && wdata[FLG_MATCH]
        && cs_sh == 3'h0 |=> !compare_irq) else $error("match flag not cleared");
    a_oe_dir: assert property (wr && addr == ADDR_PORT
        |=> compare_output_oe == $past(wdata[PORT_DIR])) else $error("pin direction wrong");
    a_port_pass: assert property (wr && addr == ADDR_PORT && com_sh == 2'b00
        |=> compare_output == $past(wdata[PORT_DATA])) else $error("port value not passed");
    a_force_set: assert property (wr_ctl && wdata[CTL_FORCE] && !wdata[CTL_WGM_LO]
        && wdata[5:4] == 2'b11 |-> ##[1:2] compare_output) else $error("force set missed");
    a_force_clr: assert property (wr_ctl && wdata[CTL_FORCE] && !wdata[CTL_WGM_LO]
        && wdata[5:4] == 2'b10 |-> ##[1:2] !compare_output) else $error("force clear missed");
    a_crystal_out: assert property ($rose(crystal_pin_in) |-> ##[1:4] !crystal_pin_out)
        else $error("crystal drive not following input");
endmodule
bind timer8_compare_waveform timer8_props u_props (.clock(clock), .arst_n(arst_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .crystal_pin_in(crystal_pin_in), .crystal_pin_out(crystal_pin_out), .irq_ack(irq_ack),
    .compare_irq(compare_irq), .overflow_irq(overflow_irq), .compare_output(compare_output),
    .compare_output_oe(compare_output_oe));
`default_nettype wire

//--- verilog/timer8_compare_waveform.sv
// Purpose: Eight-bit timer/counter with one compare unit and waveform output.
// Assumes: Crystal pin input is a slow square wave, synchronised here.
// Notes:   Asynchronous status handshake is not modelled.
`timescale 1ns/1ps
`default_nettype none

module timer8_compare_waveform
    import timer8_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       arst_n,
    input  wire logic [2:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       crystal_pin_in,
    output logic            crystal_pin_out,
    input  wire logic       irq_ack,
    output logic            compare_irq,
    output logic            overflow_irq,
    output logic            compare_output,
    output logic            compare_output_oe
);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] count_value;
    logic [7:0] compare_value;
    logic [7:0] compare_buffer;
    logic [2:0] clock_source_select;
    logic [1:0] compare_output_mode;
    logic       waveform_mode_hi;
    logic       waveform_mode_lo;
    logic       compare_match_flag;
    logic       overflow_flag;
    logic       compare_irq_enable;
    logic       overflow_irq_enable;
    logic       async_clock_select;
    logic       port_data;
    logic       output_pin_direction;
    logic       oc_state;
    logic       count_down;
    logic       block_match;
    logic       match_pending;
    logic [9:0] prescale;
    logic [2:0] xtal_sync;
    logic [7:0] next_count;
    logic       next_down;
    logic [7:0] rdata_mux;

    wave_mode_t wave;
    assign wave = wave_mode_t'({waveform_mode_hi, waveform_mode_lo});

    // ----------------------------------------
    // Tick generation
    // ----------------------------------------
    wire xtal_rise  = xtal_sync[1] & ~xtal_sync[2];
    wire base_tick  = async_clock_select ? xtal_rise : 1'b1;
    wire prescale_hit = ((prescale & tap_mask(clock_source_select)) == 10'h000);
    wire timer_tick = (clock_source_select != 3'h0) & base_tick & prescale_hit;

    // Crystal driver output drives the inverse of the synchronised input phase
    assign crystal_pin_out = ~xtal_sync[1];

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire is_pwm      = (wave == WAVE_PHASE) | (wave == WAVE_FAST);
    wire sel_ctl     = (addr == ADDR_CONTROL);
    wire sel_cnt     = (addr == ADDR_COUNT);
    wire sel_cmp     = (addr == ADDR_COMPARE);
    wire sel_flg     = (addr == ADDR_FLAGS);
    wire sel_ien     = (addr == ADDR_IRQ_EN);
    wire sel_asy     = (addr == ADDR_ASYNC);
    wire sel_port    = (addr == ADDR_PORT);
    wire cnt_write   = wr & sel_cnt;
    // Strobe follows the mode and output bits written beside it
    wire [1:0] force_mode = wdata[CTL_COM_LSB +: 2];
    wire force_write = wr & sel_ctl & wdata[CTL_FORCE] & ~wdata[CTL_WGM_LO];
    wire at_max      = (count_value == COUNT_MAX);
    wire at_bottom   = (count_value == COUNT_BOT);
    wire equal       = (count_value == compare_value);
    wire match_now   = timer_tick & equal & ~block_match;

    // Buffer update point: MAX tick in both PWM modes
    wire load_point  = timer_tick & ((wave == WAVE_FAST) ? at_max :
                                     (wave == WAVE_PHASE) ? at_max : 1'b0);

    // ----------------------------------------
    // Next count
    // ----------------------------------------
    always_comb begin
        next_count = count_value;
        next_down  = count_down;
        case (wave)
            WAVE_NORMAL: begin
                next_count = count_value + 8'h01;
                next_down  = 1'b0;
            end
            WAVE_CLEAR: begin
                next_count = equal ? COUNT_BOT : count_value + 8'h01;
                next_down  = 1'b0;
            end
            WAVE_FAST: begin
                next_count = count_value + 8'h01;
                next_down  = 1'b0;
            end
            WAVE_PHASE: begin
                if (count_down && at_bottom) begin
                    next_down  = 1'b0;
                    next_count = count_value + 8'h01;
                end else if (!count_down && at_max) begin
                    next_down  = 1'b1;
                    next_count = count_value - 8'h01;
                end else if (count_down) begin
                    next_count = count_value - 8'h01;
                end else begin
                    next_count = count_value + 8'h01;
                end
            end
            default: begin
                next_count = count_value;
            end
        endcase
    end

    // Overflow: normal/fast on MAX to zero, clear on MAX to zero unless MAX equals compare, phase correct at bottom
    wire overflow_now = timer_tick & ((wave == WAVE_PHASE) ? (count_down & at_bottom) :
                                      (at_max & ~(wave == WAVE_CLEAR & equal)));

    // ----------------------------------------
    // Waveform action
    // ----------------------------------------
    // Set, clear or toggle picked by an output mode
    function automatic logic oc_action(input logic [1:0] mode, input logic cur);
        case (mode)
            2'b01:   oc_action = ~cur;
            2'b10:   oc_action = 1'b0;
            2'b11:   oc_action = 1'b1;
            default: oc_action = cur;
        endcase
    endfunction

    logic next_oc;
    always_comb begin
        next_oc = oc_state;
        if (force_write) begin
            next_oc = oc_action(force_mode, oc_state);
        end else if (match_now && !is_pwm) begin
            next_oc = oc_action(compare_output_mode, oc_state);
        end else if (is_pwm && compare_output_mode != 2'b00) begin
            if (wave == WAVE_FAST) begin
                if (compare_output_mode == 2'b01 && match_now) begin
                    next_oc = ~oc_state;
                end else if (match_now) begin
                    next_oc = compare_output_mode[0];
                end else if (timer_tick && at_max) begin
                    next_oc = ~compare_output_mode[0];
                end
            end else if (match_now && compare_output_mode[1]) begin
                next_oc = count_down ? ~compare_output_mode[0] : compare_output_mode[0];
            end
        end
    end

    // ----------------------------------------
    // Sequential state
    // ----------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            xtal_sync <= 3'h0;
            prescale  <= 10'h000;
        end else begin
            xtal_sync <= {xtal_sync[1:0], crystal_pin_in};
            if (base_tick) begin
                prescale <= prescale + 10'h001;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            count_value <= RESET_BYTE;
            count_down  <= 1'b0;
            block_match <= 1'b0;
        end else if (cnt_write) begin
            count_value <= wdata;
            block_match <= 1'b1;
        end else if (timer_tick) begin
            count_value <= next_count;
            count_down  <= next_down;
            block_match <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            compare_value  <= RESET_BYTE;
            compare_buffer <= RESET_BYTE;
        end else begin
            if (wr && sel_cmp) begin
                compare_buffer <= wdata;
            end
            if (wr && sel_cmp && !is_pwm) begin
                compare_value <= wdata;
            end else if (is_pwm && load_point) begin
                compare_value <= compare_buffer;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            clock_source_select  <= 3'h0;
            compare_output_mode  <= 2'h0;
            waveform_mode_hi     <= 1'b0;
            waveform_mode_lo     <= 1'b0;
            compare_irq_enable   <= 1'b0;
            overflow_irq_enable  <= 1'b0;
            async_clock_select   <= 1'b0;
            port_data            <= 1'b0;
            output_pin_direction <= 1'b0;
        end else if (wr) begin
            if (sel_ctl) begin
                clock_source_select <= wdata[CTL_CS_LSB +: 3];
                waveform_mode_hi    <= wdata[CTL_WGM_HI];
                waveform_mode_lo    <= wdata[CTL_WGM_LO];
                compare_output_mode <= wdata[CTL_COM_LSB +: 2];
            end
            if (sel_ien) begin
                compare_irq_enable  <= wdata[FLG_MATCH];
                overflow_irq_enable <= wdata[FLG_OVF];
            end
            if (sel_asy) begin
                async_clock_select <= wdata[ASY_SELECT];
            end
            if (sel_port) begin
                port_data            <= wdata[PORT_DATA];
                output_pin_direction <= wdata[PORT_DIR];
            end
        end
    end

    // Set wins over a same-cycle clear so no event is lost
    wire clr_match = (wr & sel_flg & wdata[FLG_MATCH]) | (irq_ack & compare_irq);
    wire clr_ovf   = (wr & sel_flg & wdata[FLG_OVF]) | (irq_ack & overflow_irq & ~compare_irq);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            match_pending      <= 1'b0;
            compare_match_flag <= 1'b0;
            overflow_flag      <= 1'b0;
            oc_state           <= 1'b0;
        end else begin
            match_pending <= match_now ? 1'b1 : (timer_tick ? 1'b0 : match_pending);
            if (timer_tick && match_pending) begin
                compare_match_flag <= 1'b1;
            end else if (clr_match) begin
                compare_match_flag <= 1'b0;
            end
            if (overflow_now) begin
                overflow_flag <= 1'b1;
            end else if (clr_ovf) begin
                overflow_flag <= 1'b0;
            end
            oc_state <= next_oc;
        end
    end

    // ----------------------------------------
    // Outputs and read port
    // ----------------------------------------
    assign compare_irq  = compare_match_flag & compare_irq_enable;
    assign overflow_irq = overflow_flag & overflow_irq_enable;
    // Override depends only on output mode bits
    wire override = (compare_output_mode != 2'b00);
    assign compare_output    = override ? oc_state : port_data;
    assign compare_output_oe = output_pin_direction;

    always_comb begin
        rdata_mux = 8'h00;
        case (addr)
            ADDR_CONTROL: rdata_mux = {1'b0, waveform_mode_lo, compare_output_mode,
                                       waveform_mode_hi, clock_source_select};
            ADDR_COUNT:   rdata_mux = count_value;
            ADDR_COMPARE: rdata_mux = is_pwm ? compare_buffer : compare_value;
            ADDR_FLAGS:   rdata_mux = {6'h00, compare_match_flag, overflow_flag};
            ADDR_IRQ_EN:  rdata_mux = {6'h00, compare_irq_enable, overflow_irq_enable};
            ADDR_ASYNC:   rdata_mux = {4'h0, async_clock_select, 3'h0};
            ADDR_PORT:    rdata_mux = {6'h00, output_pin_direction, port_data};
            default:      rdata_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= 8'h00;
        end else begin
            rdata <= rd ? rdata_mux : 8'h00;
        end
    end

endmodule

`default_nettype wire

//--- verilog/timer8_pkg.sv
// Purpose: Constants for the eight-bit timer with one compare unit.
// Assumes: Plain register port, 8-bit data, one word per register.
// Notes:   Offsets and bit positions are local choices.

package timer8_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [2:0] ADDR_CONTROL  = 3'h0;
    localparam logic [2:0] ADDR_COUNT    = 3'h1;
    localparam logic [2:0] ADDR_COMPARE  = 3'h2;
    localparam logic [2:0] ADDR_FLAGS    = 3'h3;
    localparam logic [2:0] ADDR_IRQ_EN   = 3'h4;
    localparam logic [2:0] ADDR_ASYNC    = 3'h5;
    localparam logic [2:0] ADDR_PORT     = 3'h6;

    // ----------------------------------------
    // Control, flag, async and port register fields
    // ----------------------------------------
    localparam int CTL_CS_LSB   = 0;
    localparam int CTL_COM_LSB  = 4;
    localparam int CTL_WGM_LO   = 6;
    localparam int CTL_WGM_HI   = 3;
    localparam int CTL_FORCE    = 7;
    localparam int FLG_MATCH    = 1;
    localparam int FLG_OVF      = 0;
    localparam int ASY_SELECT   = 3;
    localparam int PORT_DATA    = 0;
    localparam int PORT_DIR     = 1;

    // ----------------------------------------
    // Reset values and constants
    // ----------------------------------------
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] COUNT_MAX  = 8'hFF;
    localparam logic [7:0] COUNT_BOT  = 8'h00;

    typedef enum logic [1:0] {
        WAVE_NORMAL = 2'b00,
        WAVE_PHASE  = 2'b01,
        WAVE_CLEAR  = 2'b10,
        WAVE_FAST   = 2'b11
    } wave_mode_t;

    // Prescaler taps for clock_source_select 1..7
    function automatic logic [9:0] tap_mask(input logic [2:0] sel);
        case (sel)
            3'h1:    tap_mask = 10'h000;
            3'h2:    tap_mask = 10'h007;
            3'h3:    tap_mask = 10'h01F;
            3'h4:    tap_mask = 10'h03F;
            3'h5:    tap_mask = 10'h07F;
            3'h6:    tap_mask = 10'h0FF;
            3'h7:    tap_mask = 10'h3FF;
            default: tap_mask = 10'h000;
        endcase
    endfunction

endpackage
